// ===== hdl/hcd_defines.vh
// Constants for the host command decoder: offsets, field positions, fixed pointer value, timing.
// Assumes a 33 MHz host bus clock; included by its bare name.
`ifndef HCD_DEFINES_VH
`define HCD_DEFINES_VH
`define HCD_OFF_HOST_COMMAND 8'h00
`define HCD_OFF_CARDBUS_PTR 8'h28
`define HCD_CARDBUS_PTR_VAL 32'h10000107
`define HCD_BIT_GO 31
`define HCD_BIT_STOP 30
`define HCD_BIT_ACK 29
`define HCD_BIT_CHSEL 21
`define HCD_BIT_EOC 20
`define HCD_BIT_RXSEL 19
`define HCD_BIT_NES 18
`define HCD_BIT_ADRST 15
`define HCD_BIT_LDTMR 14
`define HCD_BIT_LDTHR 13
`define HCD_BIT_REQINT 12
`define HCD_BIT_INTOFF 11
`define HCD_BIT_INTON 10
`define HCD_COUNT_LSB 0
`define HCD_CLK_MHZ 33
`define HCD_TICK_US 4
`define HCD_TICK_CYCLES 16'h0084
`define HCD_VEC_DELAY_CYCLES 3'h6
`endif

// ===== hdl/hcd_host_command_decoder.v
// Host command decoder: decodes host command writes into channel, interrupt and reset actions.
// Assumes single-cycle synchronous register writes/reads and DMA engines outside this block.
`include "hcd_defines.vh"

// Notes on behaviour
// - Pointer register at 0x28 reads fixed 10000107h, writes ignored.
// - Go writes start tx or rx channel by direction; bit reads zero.
// - After any reset both paths are held stopped.
// - Tx stop halts transmit after bus transfer ends, sets tx-stopped flag.
// - Rx stop resets receive after bus transfer ends, sets rx-stopped flag.
// - Frame completing during stop still posts its interrupts and end-of-channel.
// - Stop on idle channels resets them but leaves stopped flag clear.
// - Ack clears status, statistics or per-channel end-of-channel interrupt by selects.
// - Frame ack subtracts count; overacknowledge raises acknowledge error.
// - Vector update is ready six cycles after a frame acknowledge.
// - Channel select keeps only its low bit; upper bits read zero.
// - End-of-channel select picks channel vs frame, or status vs statistics.
// - Direction select routes commands to receive when one, transmit when zero.
// - Error/stat select zero picks status/statistics, one picks channel operations.
// - Bits 17 and 16 read zero; bits 9 and 8 written zero by software.
// - Adapter reset clears channels, stops paths, sets sticky reset indicator.
// - Reset with both interrupt bits also requests configuration reload.
// - Load-timer sets holdoff in 4 us units; expired timer stays expired.
// - Load-threshold applies only with end-of-channel, direction and error/stat selects zero, sets tx threshold of selected channel.
// - Raising threshold above count deasserts pending tx frame interrupt.
// - Request-interrupt creates a dummy host interrupt.
// - Interrupts-off blocks host pin, interrupts-on re-enables it.
// - Host loads aligned list address in channel parameter before go.
// - Nonzero vector write deasserts host interrupt until next acknowledge.
module hcd_host_command_decoder (
	// Clock, reset, enable
	input wire core_clk_in,
	input wire reset_n_in,
	input wire clk_en_in,
	// Register port
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	output reg [31:0] reg_rdata_out,
	// Channel parameter and vector write
	input wire [31:0] channel_parameter_in,
	input wire vector_write_nz_in,
	// Channel events from DMA engines
	input wire [1:0] tx_busy_in,
	input wire rx_busy_in,
	input wire bus_xfer_active_in,
	input wire [1:0] tx_eof_in,
	input wire [1:0] rx_eof_in,
	input wire [1:0] tx_eoc_in,
	input wire [1:0] rx_eoc_in,
	input wire status_event_in,
	input wire stats_event_in,
	// Channel controls
	output reg [1:0] tx_go_out,
	output reg [1:0] rx_go_out,
	output reg [31:0] list_addr_out,
	output wire tx_reset_out,
	output wire rx_reset_out,
	output wire tx_run_out,
	output wire rx_run_out,
	output reg transmit_stopped_flag_out,
	output reg receive_stopped_flag_out,
	output reg acknowledge_error_check_out,
	output reg adapter_reset_out,
	output reg sticky_reset_out,
	output reg config_reload_out,
	output reg vector_ready_out,
	output wire host_interrupt_pin_out
);
	localparam ST_RUN = 2'b01;
	localparam ST_STOPPING = 2'b10;
	localparam [15:0] TICK = `HCD_TICK_CYCLES;

	reg [1:0] tx_state_q;
	reg [1:0] rx_state_q;
	reg tx_run_q;
	reg rx_run_q;
	reg tx_idle_stop_q;
	reg rx_idle_stop_q;
	reg chan_q;
	reg eoc_sel_q;
	reg rx_sel_q;
	reg nes_q;
	reg [7:0] tx_eof_cnt_q [0:1];
	reg [7:0] rx_eof_cnt_q [0:1];
	reg [7:0] tx_thr_q [0:1];
	reg [1:0] tx_eoc_q;
	reg [1:0] rx_eoc_q;
	reg status_q;
	reg stats_q;
	reg dummy_q;
	reg ints_en_q;
	reg vec_block_q;
	reg [7:0] hold_q;
	reg [15:0] tick_q;
	reg [2:0] vec_dly_q;
	integer i;

	wire wr_cmd = clk_en_in & reg_wr_in & (reg_addr_in == `HCD_OFF_HOST_COMMAND);
	wire w_go = wr_cmd & reg_wdata_in[`HCD_BIT_GO];
	wire w_stop = wr_cmd & reg_wdata_in[`HCD_BIT_STOP];
	wire w_ack = wr_cmd & reg_wdata_in[`HCD_BIT_ACK];
	wire w_rst = wr_cmd & reg_wdata_in[`HCD_BIT_ADRST];
	wire w_ldtmr = wr_cmd & reg_wdata_in[`HCD_BIT_LDTMR];
	wire w_ldthr = wr_cmd & reg_wdata_in[`HCD_BIT_LDTHR];
	wire w_req = wr_cmd & reg_wdata_in[`HCD_BIT_REQINT];
	wire w_off = wr_cmd & reg_wdata_in[`HCD_BIT_INTOFF];
	wire w_on = wr_cmd & reg_wdata_in[`HCD_BIT_INTON];
	// Selects of the same write steer its command bits
	wire c_ch = reg_wdata_in[`HCD_BIT_CHSEL];
	wire c_eoc = reg_wdata_in[`HCD_BIT_EOC];
	wire c_rx = reg_wdata_in[`HCD_BIT_RXSEL];
	wire c_nes = reg_wdata_in[`HCD_BIT_NES];
	wire [7:0] c_cnt = reg_wdata_in[7:0];
	wire [7:0] sel_tx_cnt = tx_eof_cnt_q[c_ch];
	wire [7:0] sel_rx_cnt = rx_eof_cnt_q[c_ch];
	wire ack_eof = w_ack & c_nes & ~c_eoc;
	wire ack_over = ack_eof & (c_cnt > (c_rx ? sel_rx_cnt : sel_tx_cnt));

	assign tx_run_out = tx_run_q;
	assign rx_run_out = rx_run_q;
	assign tx_reset_out = ~tx_run_q;
	assign rx_reset_out = ~rx_run_q;

	// Tx frame interrupt pending only while count meets a nonzero threshold
	wire tx_eof_pend0 = (tx_thr_q[0] != 8'h00) & (tx_eof_cnt_q[0] >= tx_thr_q[0]);
	wire tx_eof_pend1 = (tx_thr_q[1] != 8'h00) & (tx_eof_cnt_q[1] >= tx_thr_q[1]);
	wire rx_eof_pend = (rx_eof_cnt_q[0] != 8'h00) | (rx_eof_cnt_q[1] != 8'h00);
	wire any_int = tx_eof_pend0 | tx_eof_pend1 | rx_eof_pend | (|tx_eoc_q) | (|rx_eoc_q) |
		status_q | stats_q | dummy_q | acknowledge_error_check_out | transmit_stopped_flag_out |
		receive_stopped_flag_out;
	// Pin is blocked by off command, holdoff timer and vector write
	assign host_interrupt_pin_out = any_int & ints_en_q & (hold_q == 8'h00) & ~vec_block_q;

	always @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			tx_state_q <= ST_STOPPING;
			rx_state_q <= ST_STOPPING;
			tx_run_q <= 1'b0;
			rx_run_q <= 1'b0;
			tx_idle_stop_q <= 1'b1;
			rx_idle_stop_q <= 1'b1;
			chan_q <= 1'b0;
			eoc_sel_q <= 1'b0;
			rx_sel_q <= 1'b0;
			nes_q <= 1'b0;
			for (i = 0; i < 2; i = i + 1)
			begin
				tx_eof_cnt_q[i] <= 8'h00;
				rx_eof_cnt_q[i] <= 8'h00;
				tx_thr_q[i] <= 8'h01;
			end
			tx_eoc_q <= 2'b00;
			rx_eoc_q <= 2'b00;
			status_q <= 1'b0;
			stats_q <= 1'b0;
			dummy_q <= 1'b0;
			ints_en_q <= 1'b1;
			vec_block_q <= 1'b0;
			hold_q <= 8'h00;
			tick_q <= 16'h0000;
			vec_dly_q <= 3'h0;
			tx_go_out <= 2'b00;
			rx_go_out <= 2'b00;
			list_addr_out <= 32'h00000000;
			transmit_stopped_flag_out <= 1'b0;
			receive_stopped_flag_out <= 1'b0;
			acknowledge_error_check_out <= 1'b0;
			adapter_reset_out <= 1'b0;
			sticky_reset_out <= 1'b0;
			config_reload_out <= 1'b0;
			vector_ready_out <= 1'b1;
		end
		else if (clk_en_in)
		begin
			tx_go_out <= 2'b00;
			rx_go_out <= 2'b00;
			adapter_reset_out <= 1'b0;
			config_reload_out <= 1'b0;
			if (wr_cmd)
			begin
				chan_q <= c_ch;
				eoc_sel_q <= c_eoc;
				rx_sel_q <= c_rx;
				nes_q <= c_nes;
			end
			// Events from the DMA engines keep posting during a stop; set wins over clear
			for (i = 0; i < 2; i = i + 1)
			begin
				tx_eof_cnt_q[i] <= tx_eof_cnt_q[i] - ((ack_eof & ~c_rx & (c_ch == i) & ~ack_over) ?
					c_cnt : 8'h00) + {7'h00, tx_eof_in[i]};
				rx_eof_cnt_q[i] <= rx_eof_cnt_q[i] - ((ack_eof & c_rx & (c_ch == i) & ~ack_over) ?
					c_cnt : 8'h00) + {7'h00, rx_eof_in[i]};
				if (w_ack & c_nes & c_eoc & ~c_rx & (c_ch == i))
					tx_eoc_q[i] <= tx_eoc_in[i];
				else if (tx_eoc_in[i])
					tx_eoc_q[i] <= 1'b1;
				if (w_ack & c_nes & c_eoc & c_rx & (c_ch == i))
					rx_eoc_q[i] <= rx_eoc_in[i];
				else if (rx_eoc_in[i])
					rx_eoc_q[i] <= 1'b1;
				if (w_ldthr & ~c_nes & ~c_eoc & ~c_rx & (c_ch == i))
					tx_thr_q[i] <= c_cnt;
			end
			if (w_ack & ~c_nes & c_eoc & c_rx)
				status_q <= status_event_in;
			else if (status_event_in)
				status_q <= 1'b1;
			if (w_ack & ~c_nes & ~c_eoc & c_rx)
				stats_q <= stats_event_in & rx_run_q;
			else if (stats_event_in & rx_run_q)
				stats_q <= 1'b1;
			if (ack_over)
				acknowledge_error_check_out <= 1'b1;
			if (w_req)
				dummy_q <= 1'b1;
			else if (w_ack)
				dummy_q <= 1'b0;
			if (w_off)
				ints_en_q <= 1'b0;
			else if (w_on)
				ints_en_q <= 1'b1;
			if (vector_write_nz_in)
				vec_block_q <= 1'b1;
			else if (w_ack)
				vec_block_q <= 1'b0;
			// Frame ack takes six cycles before the vector reflects it
			if (ack_eof)
			begin
				vec_dly_q <= `HCD_VEC_DELAY_CYCLES;
				vector_ready_out <= 1'b0;
			end
			else if (vec_dly_q != 3'h0)
			begin
				vec_dly_q <= vec_dly_q - 3'h1;
				vector_ready_out <= (vec_dly_q == 3'h1);
			end
			// Holdoff: 8-bit count of 4 us ticks restarted by each ack without load-timer
			if (tick_q != 16'h0000)
				tick_q <= tick_q - 16'h0001;
			else if (hold_q != 8'h00)
			begin
				hold_q <= hold_q - 8'h01;
				tick_q <= TICK - 16'h0001;
			end
			if (w_ldtmr & (hold_q != 8'h00))
			begin
				// Expired timer stays expired; otherwise zero ends it and a smaller value replaces the remaining count, a larger one is ignored
				if (c_cnt == 8'h00)
					hold_q <= 8'h00;
				else if (c_cnt < hold_q)
					hold_q <= c_cnt;
			end
			else if (w_ack & ~w_ldtmr)
			begin
				hold_q <= c_cnt;
				tick_q <= TICK - 16'h0001;
			end
			// Transmit path
			case (tx_state_q)
				ST_RUN:
				begin
					if (w_stop & ~c_rx)
					begin
						tx_state_q <= ST_STOPPING;
						tx_idle_stop_q <= ~(|tx_busy_in);
					end
				end
				ST_STOPPING:
				begin
					if (~bus_xfer_active_in & tx_run_q)
					begin
						tx_run_q <= 1'b0;
						transmit_stopped_flag_out <= ~tx_idle_stop_q;
					end
					if (w_go & ~c_rx)
					begin
						tx_state_q <= ST_RUN;
						tx_run_q <= 1'b1;
						transmit_stopped_flag_out <= 1'b0;
					end
				end
				default: tx_state_q <= ST_STOPPING;
			endcase
			if (w_go & ~c_rx)
			begin
				tx_go_out[c_ch] <= 1'b1;
				list_addr_out <= {channel_parameter_in[31:3], 3'b000};
			end
			// Receive path
			case (rx_state_q)
				ST_RUN:
				begin
					if (w_stop & c_rx)
					begin
						rx_state_q <= ST_STOPPING;
						rx_idle_stop_q <= ~rx_busy_in;
					end
				end
				ST_STOPPING:
				begin
					if (~bus_xfer_active_in & rx_run_q)
					begin
						rx_run_q <= 1'b0;
						receive_stopped_flag_out <= ~rx_idle_stop_q;
					end
					if (w_go & c_rx)
					begin
						rx_state_q <= ST_RUN;
						rx_run_q <= 1'b1;
						receive_stopped_flag_out <= 1'b0;
					end
				end
				default: rx_state_q <= ST_STOPPING;
			endcase
			if (w_go & c_rx)
			begin
				rx_go_out[c_ch] <= 1'b1;
				list_addr_out <= {channel_parameter_in[31:3], 3'b000};
			end
			// Adapter reset overrides path, flag, holdoff and count updates in the same write; enable, selects and vector still update
			if (w_rst)
			begin
				adapter_reset_out <= 1'b1;
				sticky_reset_out <= 1'b1;
				config_reload_out <= w_on & w_off;
				tx_state_q <= ST_STOPPING;
				rx_state_q <= ST_STOPPING;
				tx_run_q <= 1'b0;
				rx_run_q <= 1'b0;
				tx_go_out <= 2'b00;
				rx_go_out <= 2'b00;
				tx_eoc_q <= 2'b00;
				rx_eoc_q <= 2'b00;
				status_q <= 1'b0;
				stats_q <= 1'b0;
				dummy_q <= 1'b0;
				acknowledge_error_check_out <= 1'b0;
				transmit_stopped_flag_out <= 1'b0;
				receive_stopped_flag_out <= 1'b0;
				hold_q <= 8'h00;
				tick_q <= 16'h0000;
				for (i = 0; i < 2; i = i + 1)
				begin
					tx_eof_cnt_q[i] <= 8'h00;
					rx_eof_cnt_q[i] <= 8'h00;
					tx_thr_q[i] <= 8'h01;
				end
			end
		end
	end

	// Read data registered; command bits and reserved bits read zero
	always @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			reg_rdata_out <= 32'h00000000;
		else if (clk_en_in & reg_rd_in)
		begin
			if (reg_addr_in == `HCD_OFF_CARDBUS_PTR)
				reg_rdata_out <= `HCD_CARDBUS_PTR_VAL;
			else if (reg_addr_in == `HCD_OFF_HOST_COMMAND)
				reg_rdata_out <= {10'h000, chan_q, eoc_sel_q, rx_sel_q, nes_q, 18'h00000};
			else
				reg_rdata_out <= 32'h00000000;
		end
	end
endmodule // hcd_host_command_decoder

// ===== testbench/hcd_properties.sv
// Port assertions for the host command decoder.
// Bound to the decoder top; one clock domain, async active-low reset.
module hcd_properties (
	// Clock and reset
	input wire core_clk_in,
	input wire reset_n_in,
	// Register port
	input wire clk_en_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire [31:0] reg_rdata_out,
	// Events and controls
	input wire vector_write_nz_in,
	input wire bus_xfer_active_in,
	input wire rx_busy_in,
	input wire [1:0] tx_go_out,
	input wire tx_run_out,
	input wire rx_run_out,
	input wire receive_stopped_flag_out,
	input wire adapter_reset_out,
	input wire sticky_reset_out,
	input wire config_reload_out,
	input wire vector_ready_out,
	input wire host_interrupt_pin_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	wire cmd = clk_en_in && reg_wr_in && reg_addr_in == 8'h00;
	property p_cis;
		clk_en_in && reg_rd_in && reg_addr_in == 8'h28 |=> reg_rdata_out == 32'h10000107;
	endproperty
	a_cis: assert property (p_cis) else $error("pointer read wrong");
	property p_go;
		cmd && reg_wdata_in[31] && !reg_wdata_in[19] && !reg_wdata_in[15]
			|=> tx_run_out && tx_go_out == (2'b01 << $past(reg_wdata_in[21]));
	endproperty
	a_go: assert property (p_go) else $error("tx go wrong");
	property p_pulse;
		adapter_reset_out |-> $past(cmd && reg_wdata_in[15]);
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse without write");
	property p_adrst;
		adapter_reset_out |-> sticky_reset_out && !tx_run_out && !rx_run_out;
	endproperty
	a_adrst: assert property (p_adrst) else $error("adapter reset effects");
	property p_reload;
		config_reload_out |-> adapter_reset_out;
	endproperty
	a_reload: assert property (p_reload) else $error("reload without reset");
	wire fa = cmd && reg_wdata_in[29] && reg_wdata_in[18] && !reg_wdata_in[20];
	property p_vec;
		fa |=> !vector_ready_out [*6];
	endproperty
	a_vec: assert property (p_vec) else $error("vector delay wrong");
	// A later frame ack restarts the delay, so readiness is due only after a quiet stretch
	property p_vec_end;
		fa ##1 !fa [*6] |=> vector_ready_out;
	endproperty
	a_vec_end: assert property (p_vec_end) else $error("vector not ready");
	property p_stop;
		$fell(tx_run_out) && !adapter_reset_out |-> !$past(bus_xfer_active_in);
	endproperty
	a_stop: assert property (p_stop) else $error("tx stopped mid transfer");
	property p_idle;
		cmd && reg_wdata_in[30] && reg_wdata_in[19] && !rx_busy_in && !receive_stopped_flag_out
			|=> !receive_stopped_flag_out [*8];
	endproperty
	a_idle: assert property (p_idle) else $error("idle rx flag set");
	property p_off;
		cmd && reg_wdata_in[11] && !reg_wdata_in[10] |=> !host_interrupt_pin_out;
	endproperty
	a_off: assert property (p_off) else $error("pin with ints off");
	property p_vnz;
		clk_en_in && vector_write_nz_in |=> !host_interrupt_pin_out;
	endproperty
	a_vnz: assert property (p_vnz) else $error("pin after vector write");
endmodule // hcd_properties

bind hcd_host_command_decoder hcd_properties u_props (
	.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.vector_write_nz_in(vector_write_nz_in), .bus_xfer_active_in(bus_xfer_active_in),
	.rx_busy_in(rx_busy_in), .tx_go_out(tx_go_out), .tx_run_out(tx_run_out),
	.rx_run_out(rx_run_out), .receive_stopped_flag_out(receive_stopped_flag_out),
	.adapter_reset_out(adapter_reset_out), .sticky_reset_out(sticky_reset_out),
	.config_reload_out(config_reload_out), .vector_ready_out(vector_ready_out),
	.host_interrupt_pin_out(host_interrupt_pin_out));

// ===== testbench/hcd_dma_model.sv
// Model of the list DMA engines beside the decoder.
// Busy follows go pulses; when slow, transfers run 8 of every 12 cycles.
module hcd_dma_model (
	// Clock and reset
	input wire core_clk_in,
	input wire reset_n_in,
	// Mode and decoder controls
	input wire slow_in,
	input wire [1:0] tx_go_in,
	input wire [1:0] rx_go_in,
	input wire tx_run_in,
	input wire rx_run_in,
	// Engine status
	output reg [1:0] tx_busy_out,
	output reg rx_busy_out,
	output wire bus_xfer_out,
	output wire [1:0] tx_eof_out,
	output wire rx_eof_out
);
	reg [3:0] phase_q;
	assign bus_xfer_out = slow_in && phase_q < 4'h8;
	// A frame ends as each transfer closes
	assign tx_eof_out = (slow_in && phase_q == 4'h8) ? tx_busy_out : 2'b00;
	assign rx_eof_out = slow_in && phase_q == 4'h8 && rx_busy_out;
	always @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			phase_q <= 4'h0;
			tx_busy_out <= 2'b00;
			rx_busy_out <= 1'b0;
		end
		else
		begin
			phase_q <= (phase_q == 4'hb) ? 4'h0 : phase_q + 4'h1;
			// Busy drops once the decoder resets the path
			tx_busy_out <= tx_run_in ? (tx_busy_out | tx_go_in) : 2'b00;
			rx_busy_out <= rx_run_in && (rx_busy_out || rx_go_in[0]);
		end
	end
endmodule // hcd_dma_model

// ===== testbench/tb.sv
// Self-checking bench for the host command decoder.
// Assumes the DMA model drives engine status; 100 MHz clock.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, vwr = 1'b0, slow = 1'b1;
	reg [7:0] addr = 8'h00;
	reg [31:0] wdata = 32'h0, chp = 32'h12345678;
	wire [31:0] rdata, laddr;
	wire [1:0] tx_go, rx_go, tx_busy, tx_eof;
	wire tx_rst, rx_rst, tx_run, rx_run, tx_flag, rx_flag, ack_err, ad_rst, sticky;
	wire reload, vec_rdy, pin, rx_busy, xfer, rx_eof;
	integer fail_count = 0, checked = 0, k;
	hcd_host_command_decoder uut (
		.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .channel_parameter_in(chp), .vector_write_nz_in(vwr),
		.tx_busy_in(tx_busy), .rx_busy_in(rx_busy), .bus_xfer_active_in(xfer),
		.tx_eof_in(tx_eof), .rx_eof_in({1'b0, rx_eof}), .tx_eoc_in(2'b00),
		.rx_eoc_in(2'b00), .status_event_in(1'b0), .stats_event_in(1'b0),
		.tx_go_out(tx_go), .rx_go_out(rx_go), .list_addr_out(laddr),
		.tx_reset_out(tx_rst), .rx_reset_out(rx_rst), .tx_run_out(tx_run),
		.rx_run_out(rx_run), .transmit_stopped_flag_out(tx_flag),
		.receive_stopped_flag_out(rx_flag), .acknowledge_error_check_out(ack_err),
		.adapter_reset_out(ad_rst), .sticky_reset_out(sticky),
		.config_reload_out(reload), .vector_ready_out(vec_rdy),
		.host_interrupt_pin_out(pin));
	hcd_dma_model u_dma (
		.core_clk_in(clk), .reset_n_in(rst_n), .slow_in(slow), .tx_go_in(tx_go),
		.rx_go_in(rx_go), .tx_run_in(tx_run), .rx_run_in(rx_run),
		.tx_busy_out(tx_busy), .rx_busy_out(rx_busy), .bus_xfer_out(xfer),
		.tx_eof_out(tx_eof), .rx_eof_out(rx_eof));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task chk(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("Error %0s expected %h seen %h", name, exp, got);
		end
	end
	endtask
	task print_verdict;
	begin
		$display("Checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// Bits 9 and 8 always go out as zero
	task wr_reg(input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d & 32'hfffffcff;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	end
	endtask
	task rd_reg(input [7:0] a, input [31:0] exp);
	begin
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", exp, rdata);
	end
	endtask
	// Stop completes only once the current transfer is over
	task wait_idle;
	begin
		k = 0;
		while (xfer !== 1'b0 && k < 20)
		begin
			@(posedge clk);
			#1;
			k = k + 1;
		end
		chk("xfer_end", 0, xfer);
		repeat (2) @(posedge clk);
		#1;
	end
	endtask
	initial
	begin
		#300000;
		fail_count = fail_count + 1;
		print_verdict;
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("tx_run", 0, tx_run);
		chk("rx_run", 0, rx_run);
		chk("tx_rst", 1, tx_rst);
		wr_reg(8'h28, 32'h0);
		rd_reg(8'h28, 32'h10000107);
		wr_reg(8'h00, 32'h1fff0000);
		rd_reg(8'h00, 32'h003c0000);
		chk("pin", 0, pin);
		wr_reg(8'h00, 32'h00001000);
		@(posedge clk);
		#1;
		chk("pin", 1, pin);
		wr_reg(8'h00, 32'h00000800);
		chk("pin", 0, pin);
		wr_reg(8'h00, 32'h00000400);
		@(posedge clk);
		#1;
		chk("pin", 1, pin);
		@(posedge clk);
		vwr <= 1'b1;
		@(posedge clk);
		vwr <= 1'b0;
		#1;
		chk("pin", 0, pin);
		wr_reg(8'h00, 32'h200c0000);
		chk("pin", 0, pin);
		wr_reg(8'h00, 32'h20040001);
		chk("vec_rdy", 0, vec_rdy);
		repeat (5) @(posedge clk);
		#1;
		chk("vec_rdy", 0, vec_rdy);
		@(posedge clk);
		#1;
		chk("vec_rdy", 1, vec_rdy);
		chk("ack_err", 1, ack_err);
		wr_reg(8'h00, 32'h40080000);
		wait_idle;
		chk("rx_flag", 0, rx_flag);
		wr_reg(8'h00, 32'h80200000);
		chk("tx_go", 2'b10, tx_go);
		chk("list_addr", 32'h12345678, laddr);
		wr_reg(8'h00, 32'h80080000);
		chk("rx_go", 2'b01, rx_go);
		chk("tx_go", 0, tx_go);
		wr_reg(8'h00, 32'h40000000);
		wait_idle;
		chk("tx_run", 0, tx_run);
		chk("tx_flag", 1, tx_flag);
		wr_reg(8'h00, 32'h40080000);
		wait_idle;
		chk("rx_flag", 1, rx_flag);
		chk("rx_rst", 1, rx_rst);
		wr_reg(8'h00, 32'h00008c00);
		chk("ad_rst", 1, ad_rst);
		chk("reload", 1, reload);
		chk("sticky", 1, sticky);
		@(posedge clk);
		#1;
		chk("ad_rst", 0, ad_rst);
		chk("ack_err", 0, ack_err);
		// Holdoff of two units spans 264 clocks at the 33-cycle-per-us pacing
		wr_reg(8'h00, 32'h00000400);
		wr_reg(8'h00, 32'h20001002);
		chk("pin", 0, pin);
		repeat (259) @(posedge clk);
		#1;
		chk("pin", 0, pin);
		repeat (6) @(posedge clk);
		#1;
		chk("pin", 1, pin);
		wr_reg(8'h00, 32'h00004005);
		chk("pin", 1, pin);
		wr_reg(8'h00, 32'h20000000);
		wr_reg(8'h00, 32'h80000000);
		repeat (30) @(posedge clk);
		#1;
		chk("pin", 1, pin);
		wr_reg(8'h00, 32'h000020ff);
		chk("pin", 0, pin);
		wr_reg(8'h00, 32'h00002000);
		chk("pin", 0, pin);
		print_verdict;
	end
endmodule // tb
